/* pkg/acs_pkg.sv */
/*
  Constants, register map and types of the accelerometer SPI sequencer.
  Assumes a 250 MHz system clock and 16-bit SPI words, MSB first.
*/
package acs_pkg;

  localparam int WORD_W = 16;
  localparam int CLK_PERIOD_NS = 4;

  // Operation times (us) and cycle counts, least times rounded up
  localparam int ACC_TEST_US = 100;
  localparam int FLASH_TEST_US = 100;
  localparam int RST_RECOVERY_US = 100;
  localparam int ACC_TEST_CYC =
    (ACC_TEST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_TEST_CYC =
    (FLASH_TEST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_RECOVERY_CYC =
    (RST_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // Command word fields
  localparam int WR_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;

  // Byte addresses, window 0
  localparam logic [6:0] ADDR_BURST = 7'h00;
  localparam logic [6:0] ADDR_MODE = 7'h02;
  localparam logic [6:0] ADDR_MODE_H = 7'h03;
  localparam logic [6:0] ADDR_DIAG = 7'h04;
  localparam logic [6:0] ADDR_COUNT = 7'h0a;
  localparam logic [6:0] ADDR_TEMP_H = 7'h0e;
  localparam logic [6:0] ADDR_TEMP_L = 7'h10;
  localparam logic [6:0] ADDR_AXIS_FIRST = 7'h30;
  localparam logic [6:0] ADDR_AXIS_LAST = 7'h3a;
  // Byte addresses, window 1
  localparam logic [6:0] ADDR_MISC = 7'h02;
  localparam logic [6:0] ADDR_MISC_H = 7'h03;
  localparam logic [6:0] ADDR_RATE = 7'h04;
  localparam logic [6:0] ADDR_RATE_H = 7'h05;
  localparam logic [6:0] ADDR_UART = 7'h08;
  localparam logic [6:0] ADDR_GLOB = 7'h0a;
  localparam logic [6:0] ADDR_BCTL = 7'h0c;
  localparam logic [6:0] ADDR_BCTL_H = 7'h0d;
  // Both windows
  localparam logic [6:0] ADDR_WIN = 7'h7e;

  // Command values
  localparam logic [7:0] WIN_ZERO = 8'h00;
  localparam logic [7:0] WIN_ONE = 8'h01;
  localparam logic [7:0] MODE_SAMPLE = 8'h01;
  localparam logic [7:0] MODE_CONFIG = 8'h02;
  localparam logic [7:0] TEST_ACC = 8'h04;
  localparam logic [7:0] TEST_FLASH = 8'h08;
  localparam int GLOB_SWRST_BIT = 7;
  localparam logic [7:0] MODE_STAT_CFG = 8'h04;
  localparam logic [7:0] MODE_STAT_SMP = 8'h01;

  // Field positions
  localparam int MISC_ACC_BUSY = 10;
  localparam int MISC_FLASH_BUSY = 11;
  localparam int DIAG_ACC_LO = 12;
  localparam int DIAG_FLASH = 2;
  localparam int BCTL_COUNT = 1;
  localparam int BCTL_TEMP = 6;
  localparam int BCTL_X = 2;
  localparam int BCTL_Y = 1;
  localparam int BCTL_Z = 0;

  // Reset values
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] UART_RST = 8'h00;
  localparam logic [7:0] BCTL_RST = 8'h00;

  // Burst word slots: temp H/L, X H/L, Y H/L, Z H/L, counter
  localparam int SET_WORDS = 8;
  localparam logic [3:0] IDX_COUNT = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'h9;

  typedef enum logic {ACS_CONFIG, ACS_SAMPLING} acs_mode_t;

endpackage : acs_pkg

/* rtl/acs_spi_link.sv */
/*
  SPI link end: 16-bit word shifter in the SPI clock domain, mode 3.
  Assumes one word per chip-select frame and a reply word that the
  system side holds stable while chip select is high.
*/
module acs_spi_link (
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  input wire logic linkRstN,
  input wire logic [15:0] txWord,
  output logic spiMiso,
  output logic spiMisoOe,
  output logic [15:0] rxWord,
  output logic rxToggle
);

  logic [4:0] bitCnt_ff;
  logic [15:0] rxShift_ff;
  logic [15:0] txShift_ff;
  logic loaded_ff;

  // Bit counter, cleared between frames
  always_ff @(posedge spiSclk or posedge spiCsN) begin
    if (spiCsN) begin
      bitCnt_ff <= 5'h00;
    end else if (bitCnt_ff != 5'h10) begin
      bitCnt_ff <= bitCnt_ff + 5'h01;
    end
  end

  // Receive MSB first on rising edges
  always_ff @(posedge spiSclk) begin
    rxShift_ff <= {rxShift_ff[14:0], spiMosi}; // RL1
  end

  // Completed word and its event toggle
  always_ff @(posedge spiSclk or negedge linkRstN) begin
    if (!linkRstN) begin
      rxWord <= 16'h0000;
      rxToggle <= 1'b0;
    end else if (bitCnt_ff == 5'h0f) begin
      rxWord <= {rxShift_ff[14:0], spiMosi}; // RL1
      rxToggle <= ~rxToggle;
    end
  end

  // Transmit MSB first, changing on falling edges
  always_ff @(negedge spiSclk or posedge spiCsN) begin
    if (spiCsN) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
    end
  end

  always_ff @(negedge spiSclk) begin
    if (!loaded_ff) begin
      txShift_ff <= txWord; // RL1
    end else begin
      txShift_ff <= {txShift_ff[14:0], 1'b0};
    end
  end

  assign spiMiso = loaded_ff ? txShift_ff[15] : txWord[15]; // RL1
  assign spiMisoOe = ~spiCsN;

endmodule : acs_spi_link

/* rtl/acs_sequencer.sv */
/*
  Accelerometer SPI command sequencer: window select, mode control,
  pipelined reads, burst output, self-test, flash test, software reset.
  Assumes sensor sample words and test results arrive on mclk, and a
  chip-select gap of at least 40 ns after each word's last SCLK edge.
*/
// Summary of operation
// (RL1) 16-bit words, MSB first, byte writes
// (RL2) Writes return no data word, except the burst trigger
// (RL3) Window select by writing low byte
// (RL4) Write top bit set; 0x01 enters sampling
// (RL5) Sample rate byte written before sampling
// (RL6) Host disables UART auto sampling first
// (RL7) Read returns register in next transfer
// (RL8) Sample words read at ascending addresses
// (RL9) Host waits for data ready each sample
// (RL10) Mode write 0x02 returns to configuration
// (RL11) Burst control low 0x02 adds counter
// (RL12) Burst control high 0x47 adds temp, axes
// (RL13) Burst trigger then one word per transfer
// (RL14) Misc control 0x04 starts self-test
// (RL15) Self-test busy bit 10 until done
// (RL16) Self-test result in diag bits 15:12
// (RL17) Misc control 0x08 starts flash test
// (RL18) Flash test result in diag bit 2
// (RL19) Global command 0x80 starts software reset
// (RL20) Host waits reset recovery before commands
// (RL21) Data ready on new set, words held
// (RL22) Busy bits read one from start write
module acs_sequencer #(
  parameter int AccTestCycles = acs_pkg::ACC_TEST_CYC,
  parameter int FlashTestCycles = acs_pkg::FLASH_TEST_CYC,
  parameter int RstRecoveryCycles = acs_pkg::RST_RECOVERY_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  input wire logic sampleStrobe,
  input wire logic [31:0] tempIn,
  input wire logic [31:0] xAccIn,
  input wire logic [31:0] yAccIn,
  input wire logic [31:0] zAccIn,
  input wire logic [3:0] accTestFail,
  input wire logic flashTestFail,
  output logic dataReady,
  output logic samplingActive,
  output logic [7:0] sampleRate,
  output logic [7:0] uartCtrl,
  output logic swResetActive
);

  logic [15:0] rxWord;
  logic rxToggle;
  logic rxSync1_ff;
  logic rxSync2_ff;
  logic rxSync3_ff;
  logic [15:0] txWord_ff;
  logic [7:0] windowSel_ff;
  acs_pkg::acs_mode_t mode_ff;
  logic [7:0] rate_ff;
  logic [7:0] uart_ff;
  logic [7:0] bctlLo_ff;
  logic [7:0] bctlHi_ff;
  logic accBusy_ff;
  logic flashBusy_ff;
  logic [acs_pkg::CNT_W-1:0] testCnt_ff;
  logic [3:0] accErr_ff;
  logic flashErr_ff;
  logic [acs_pkg::CNT_W-1:0] swRstCnt_ff;
  logic [15:0] sampleSet_ff [acs_pkg::SET_WORDS];
  logic [15:0] count_ff;
  logic dataReady_ff;
  logic burstOn_ff;
  logic [3:0] burstIdx_ff;

  acs_spi_link u_link (
    .spiSclk(spiSclk),
    .spiCsN(spiCsN),
    .spiMosi(spiMosi),
    .linkRstN(resetn),
    .txWord(txWord_ff),
    .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe),
    .rxWord(rxWord),
    .rxToggle(rxToggle)
  );

  // Word event crossing from the link domain
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rxSync1_ff <= 1'b0;
      rxSync2_ff <= 1'b0;
      rxSync3_ff <= 1'b0;
    end else begin
      rxSync1_ff <= rxToggle;
      rxSync2_ff <= rxSync1_ff;
      rxSync3_ff <= rxSync2_ff;
    end
  end

  logic wordEvt;
  logic swRstBusy;
  logic rstAll;
  logic isWrite;
  logic [6:0] cmdAddr;
  logic [7:0] cmdData;
  logic cmdEvt;
  logic wrEvt;
  logic rdEvt;
  logic win1;
  logic sampling;

  assign wordEvt = rxSync2_ff ^ rxSync3_ff;
  assign swRstBusy = swRstCnt_ff != '0;
  assign rstAll = !resetn || swRstBusy;
  assign isWrite = rxWord[acs_pkg::WR_BIT];
  assign cmdAddr = rxWord[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO];
  assign cmdData = rxWord[acs_pkg::DATA_HI:0];
  assign cmdEvt = wordEvt && !swRstBusy && !burstOn_ff; // RL20
  assign wrEvt = cmdEvt && isWrite; // RL4
  assign rdEvt = cmdEvt && !isWrite; // RL7
  assign win1 = windowSel_ff == acs_pkg::WIN_ONE;
  assign sampling = mode_ff == acs_pkg::ACS_SAMPLING;

  // Write decode
  logic wrMode;
  logic goSample;
  logic goConfig;
  logic burstTrig;
  logic wrMisc;
  logic startAcc;
  logic startFlash;
  logic swRstReq;
  logic rdCount;
  logic testIdle;

  assign testIdle = !accBusy_ff && !flashBusy_ff;
  assign wrMode = wrEvt && !win1 && cmdAddr == acs_pkg::ADDR_MODE_H;
  assign goSample = wrMode && cmdData == acs_pkg::MODE_SAMPLE; // RL4
  assign goConfig = wrMode && cmdData == acs_pkg::MODE_CONFIG; // RL10
  assign burstTrig = wrEvt && !win1 && sampling &&
                     cmdAddr == acs_pkg::ADDR_BURST; // RL13
  assign wrMisc = wrEvt && win1 && cmdAddr == acs_pkg::ADDR_MISC_H;
  assign startAcc = wrMisc && testIdle &&
                    cmdData == acs_pkg::TEST_ACC; // RL14
  assign startFlash = wrMisc && testIdle &&
                      cmdData == acs_pkg::TEST_FLASH; // RL17
  assign swRstReq = wrEvt && win1 && cmdAddr == acs_pkg::ADDR_GLOB &&
                    cmdData[acs_pkg::GLOB_SWRST_BIT]; // RL19
  assign rdCount = rdEvt && !win1 && cmdAddr == acs_pkg::ADDR_COUNT;

  // Software reset recovery counter
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      swRstCnt_ff <= '0;
    end else if (swRstReq) begin
      swRstCnt_ff <= acs_pkg::CNT_W'(RstRecoveryCycles); // RL19
    end else if (swRstBusy) begin
      swRstCnt_ff <= swRstCnt_ff - 1'b1; // RL20
    end
  end

  // Window select, valid in both windows
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      windowSel_ff <= acs_pkg::WIN_ZERO;
    end else if (wrEvt && cmdAddr == acs_pkg::ADDR_WIN) begin
      windowSel_ff <= cmdData; // RL3
    end
  end

  // Operating mode
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      mode_ff <= acs_pkg::ACS_CONFIG;
    end else if (goSample) begin
      mode_ff <= acs_pkg::ACS_SAMPLING; // RL4
    end else if (goConfig) begin
      mode_ff <= acs_pkg::ACS_CONFIG; // RL10
    end
  end

  // Configuration bytes of window 1
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      rate_ff <= acs_pkg::RATE_RST;
      uart_ff <= acs_pkg::UART_RST;
      bctlLo_ff <= acs_pkg::BCTL_RST;
      bctlHi_ff <= acs_pkg::BCTL_RST;
    end else if (wrEvt && win1) begin
      case (cmdAddr)
        acs_pkg::ADDR_RATE_H: begin
          rate_ff <= cmdData; // RL5
        end
        acs_pkg::ADDR_UART: begin
          uart_ff <= cmdData; // RL6
        end
        acs_pkg::ADDR_BCTL: begin
          bctlLo_ff <= cmdData; // RL11
        end
        acs_pkg::ADDR_BCTL_H: begin
          bctlHi_ff <= cmdData; // RL12
        end
        default: begin
        end
      endcase
    end
  end

  // Self-test and flash test sequencing
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      accBusy_ff <= 1'b0;
      flashBusy_ff <= 1'b0;
      testCnt_ff <= '0;
      accErr_ff <= 4'h0;
      flashErr_ff <= 1'b0;
    end else if (startAcc) begin
      accBusy_ff <= 1'b1; // RL22
      testCnt_ff <= acs_pkg::CNT_W'(AccTestCycles - 1);
    end else if (startFlash) begin
      flashBusy_ff <= 1'b1; // RL22
      testCnt_ff <= acs_pkg::CNT_W'(FlashTestCycles - 1);
    end else if (!testIdle) begin
      if (testCnt_ff != '0) begin
        testCnt_ff <= testCnt_ff - 1'b1;
      end else if (accBusy_ff) begin
        accBusy_ff <= 1'b0; // RL15
        accErr_ff <= accTestFail; // RL16
      end else begin
        flashBusy_ff <= 1'b0; // RL17
        flashErr_ff <= flashTestFail; // RL18
      end
    end
  end

  // Sample set latch while sampling
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      for (int i = 0; i < acs_pkg::SET_WORDS; i++) begin
        sampleSet_ff[i] <= 16'h0000;
      end
      count_ff <= 16'h0000;
    end else if (sampling && sampleStrobe) begin
      sampleSet_ff[0] <= tempIn[31:16]; // RL21
      sampleSet_ff[1] <= tempIn[15:0];
      sampleSet_ff[2] <= xAccIn[31:16];
      sampleSet_ff[3] <= xAccIn[15:0];
      sampleSet_ff[4] <= yAccIn[31:16];
      sampleSet_ff[5] <= yAccIn[15:0];
      sampleSet_ff[6] <= zAccIn[31:16];
      sampleSet_ff[7] <= zAccIn[15:0];
      count_ff <= count_ff + 16'h0001;
    end
  end

  function automatic logic [15:0] wordAt(input logic [3:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    if (idx == acs_pkg::IDX_COUNT) begin
      w = count_ff;
    end else if (idx < acs_pkg::IDX_COUNT) begin
      w = sampleSet_ff[idx[2:0]];
    end
    return w;
  endfunction : wordAt

  function automatic logic [3:0] nextIdx(input logic [3:0] from,
                                         input logic [8:0] mask);
    logic [3:0] r;
    r = acs_pkg::IDX_NONE;
    for (int i = 8; i >= 0; i--) begin
      if (mask[i] && 4'(i) >= from) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : nextIdx

  // Burst slot selection
  logic [8:0] burstMask;
  logic [3:0] burstFrom;
  logic [3:0] burstNxt;
  logic burstEnd;

  assign burstMask = {bctlLo_ff[acs_pkg::BCTL_COUNT],
                      {2{bctlHi_ff[acs_pkg::BCTL_Z]}},
                      {2{bctlHi_ff[acs_pkg::BCTL_Y]}},
                      {2{bctlHi_ff[acs_pkg::BCTL_X]}},
                      {2{bctlHi_ff[acs_pkg::BCTL_TEMP]}}}; // RL11 RL12
  assign burstFrom = burstOn_ff ? burstIdx_ff + 4'h1 : 4'h0;
  assign burstNxt = nextIdx(burstFrom, burstMask); // RL13
  assign burstEnd = wordEvt && burstOn_ff &&
                    burstNxt == acs_pkg::IDX_NONE;

  // Register read mux for the current window
  logic [15:0] readWord;
  logic [6:0] axisOff;

  assign axisOff = cmdAddr - acs_pkg::ADDR_AXIS_FIRST;

  always_comb begin
    readWord = 16'h0000;
    if (cmdAddr == acs_pkg::ADDR_WIN) begin
      readWord = {8'h00, windowSel_ff};
    end else if (win1) begin
      case (cmdAddr)
        acs_pkg::ADDR_MISC: begin
          readWord[acs_pkg::MISC_ACC_BUSY] = accBusy_ff; // RL15
          readWord[acs_pkg::MISC_FLASH_BUSY] = flashBusy_ff; // RL17
        end
        acs_pkg::ADDR_RATE: begin
          readWord = {rate_ff, 8'h00};
        end
        acs_pkg::ADDR_UART: begin
          readWord = {8'h00, uart_ff};
        end
        acs_pkg::ADDR_BCTL: begin
          readWord = {bctlHi_ff, bctlLo_ff};
        end
        default: begin
          readWord = 16'h0000;
        end
      endcase
    end else begin
      case (cmdAddr)
        acs_pkg::ADDR_MODE: begin
          readWord = {sampling ? acs_pkg::MODE_STAT_SMP :
                      acs_pkg::MODE_STAT_CFG, 8'h00};
        end
        acs_pkg::ADDR_DIAG: begin
          readWord[acs_pkg::DIAG_ACC_LO+:4] = accErr_ff; // RL16
          readWord[acs_pkg::DIAG_FLASH] = flashErr_ff; // RL18
        end
        acs_pkg::ADDR_COUNT: begin
          readWord = count_ff; // RL8
        end
        acs_pkg::ADDR_TEMP_H: begin
          readWord = sampleSet_ff[0]; // RL8
        end
        acs_pkg::ADDR_TEMP_L: begin
          readWord = sampleSet_ff[1];
        end
        default: begin
          if (cmdAddr >= acs_pkg::ADDR_AXIS_FIRST &&
              cmdAddr <= acs_pkg::ADDR_AXIS_LAST && !cmdAddr[0]) begin
            readWord = wordAt(4'(axisOff[6:1]) + 4'h2); // RL8
          end
        end
      endcase
    end
  end

  // Reply word for the next transfer
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      txWord_ff <= 16'h0000;
    end else if (wordEvt) begin
      if (burstOn_ff || burstTrig) begin
        txWord_ff <= wordAt(burstNxt); // RL13
      end else if (rdEvt) begin
        txWord_ff <= readWord; // RL7
      end else begin
        txWord_ff <= 16'h0000; // RL2
      end
    end
  end

  // Burst progress
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      burstOn_ff <= 1'b0;
      burstIdx_ff <= acs_pkg::IDX_NONE;
    end else if (burstTrig || (wordEvt && burstOn_ff)) begin
      burstOn_ff <= burstNxt != acs_pkg::IDX_NONE; // RL13
      burstIdx_ff <= burstNxt;
    end
  end

  // Data ready: a new sample wins over a clearing read
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      dataReady_ff <= 1'b0;
    end else if (sampling && sampleStrobe) begin
      dataReady_ff <= 1'b1; // RL21
    end else if (rdCount || burstEnd || goConfig) begin
      dataReady_ff <= 1'b0; // RL9
    end
  end

  assign dataReady = dataReady_ff;
  assign samplingActive = sampling;
  assign sampleRate = rate_ff;
  assign uartCtrl = uart_ff;
  assign swResetActive = swRstBusy;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_wr_no_data;
    wrEvt && !swRstReq && !burstTrig |=> txWord_ff == 16'h0000;
  endproperty
  a_wr_no_data: assert property (p_wr_no_data) // RL2
    else $error("write produced a reply word");

  property p_enter_sampling;
    goSample && !swRstBusy |=> sampling && samplingActive;
  endproperty
  a_enter_sampling: assert property (p_enter_sampling) // RL4
    else $error("sampling mode not entered");

  property p_leave_sampling;
    goConfig && !(sampling && sampleStrobe) |=> !sampling ##0 !dataReady;
  endproperty
  a_leave_sampling: assert property (p_leave_sampling) // RL10
    else $error("configuration mode not restored");

  property p_acc_busy_hold;
    startAcc |=> accBusy_ff [*8];
  endproperty
  a_acc_busy_hold: assert property (p_acc_busy_hold) // RL15
    else $error("self-test busy dropped early");

  property p_acc_result;
    $fell(accBusy_ff) && !$past(rstAll) |->
      accErr_ff == $past(accTestFail);
  endproperty
  a_acc_result: assert property (p_acc_result) // RL16
    else $error("self-test result not captured");

  property p_flash_busy;
    startFlash |=> flashBusy_ff ##1 flashBusy_ff;
  endproperty
  a_flash_busy: assert property (p_flash_busy) // RL17
    else $error("flash test busy not held");

  property p_flash_result;
    $fell(flashBusy_ff) && !$past(rstAll) |->
      flashErr_ff == $past(flashTestFail);
  endproperty
  a_flash_result: assert property (p_flash_result) // RL18
    else $error("flash test result not captured");

  property p_swrst;
    swRstReq |=> swResetActive ##1 !sampling && windowSel_ff == 8'h00;
  endproperty
  a_swrst: assert property (p_swrst) // RL19
    else $error("software reset not applied");

  property p_drdy_set;
    sampling && sampleStrobe && !swRstReq && !swRstBusy |=> dataReady;
  endproperty
  a_drdy_set: assert property (p_drdy_set) // RL21
    else $error("data ready missing after sample");

  property p_burst_start;
    burstTrig && burstMask[0] |=> burstOn_ff &&
      txWord_ff == $past(sampleSet_ff[0]);
  endproperty
  a_burst_start: assert property (p_burst_start) // RL13
    else $error("burst did not start with temperature");

  c_sampling: cover property (goSample ##[1:200] sampleStrobe);
  c_burst_end: cover property (burstTrig ##[1:1000] burstEnd);
  c_acc_done: cover property (startAcc ##1 accBusy_ff ##[1:1000] !accBusy_ff);
  c_count_read: cover property (dataReady ##1 rdCount);

endmodule : acs_sequencer

/* tb/acs_host_model.sv */
/*
  SPI host model: mode 3 word frames, one 16-bit word per frame.
  Assumes the device samples MOSI on SCLK rise and drives MISO on fall.
*/
module acs_host_model (
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels set after time zero so the link sees a clean frame end
  initial begin
    #1;
    spiCsN = 1'b1;
    spiSclk = 1'b1;
    spiMosi = 1'b0;
  end
  // Frame with clock still between frames, off the system clock edges
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #0.5 spiCsN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #32 spiSclk = 1'b0;
      spiMosi = tx[i];
      #32 spiSclk = 1'b1;
      rx[i] = spiMisoOe ? spiMiso : 1'bx;
    end
    #64 spiCsN = 1'b1;
    spiMosi = ~spiMosi;
    #99.5;
  endtask : xfer
endmodule : acs_host_model

/* tb/acs_sequencer_bench.sv */
/*
  Bench of the SPI sequencer: host model on the link, sensor on mclk.
  Assumes short test and recovery counts set at the instance.
*/
module acs_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, resetn, sclk, csN, mosi, miso, misoOe, strobe;
  logic [31:0] temp, xAcc, yAcc, zAcc;
  logic [3:0] accFail;
  logic flashFail, dataReady, samplingActive, swResetActive;
  logic [7:0] sampleRate, uartCtrl;
  logic [15:0] r, cnt;
  logic [15:0] ex [9];
  int nFail, checked;

  acs_host_model i_host (.spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi),
    .spiMiso(miso), .spiMisoOe(misoOe));
  acs_sequencer #(.AccTestCycles(1000), .FlashTestCycles(1000),
    .RstRecoveryCycles(600)) i_dut (.mclk(mclk), .resetn(resetn),
    .spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi), .spiMiso(miso),
    .spiMisoOe(misoOe), .sampleStrobe(strobe), .tempIn(temp),
    .xAccIn(xAcc), .yAccIn(yAcc), .zAccIn(zAcc), .accTestFail(accFail),
    .flashTestFail(flashFail), .dataReady(dataReady),
    .samplingActive(samplingActive), .sampleRate(sampleRate),
    .uartCtrl(uartCtrl), .swResetActive(swResetActive));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic results;
    if (nFail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic tx(input logic [15:0] w);
    i_host.xfer(w, r);
  endtask : tx

  task automatic sampleSet(input logic [31:0] b);
    int n;
    @(negedge mclk);
    {temp, xAcc, yAcc, zAcc} = {b, ~b, {b[15:0], b[31:16]}, b ^ 32'h5a5a};
    strobe = 1'b1;
    @(negedge mclk);
    strobe = 1'b0;
    cnt = cnt + 16'h1;
    ex = '{temp[31:16], temp[15:0], xAcc[31:16], xAcc[15:0], yAcc[31:16],
      yAcc[15:0], zAcc[31:16], zAcc[15:0], cnt};
    for (n = 0; n < 10 && dataReady !== 1'b1; n++) @(negedge mclk);
    chk({15'h0, dataReady}, 16'h1);
    if (n == 10) results();
  endtask : sampleSet

  task automatic configure;
    tx(16'h0200);
    tx(16'h0000);
    chk(r, 16'h0400);
    tx(16'hfe01);
    tx(16'h8504);
    chk(r, 16'h0000);
    tx(16'h8855);
    chk({8'h0, uartCtrl}, 16'h0055);
    tx(16'h8800);
    chk({uartCtrl, sampleRate}, 16'h0004);
    tx(16'h8c02);
    tx(16'h8d47);
    tx(16'h0c00);
    tx(16'hfe00);
    chk(r, 16'h4702);
    tx(16'h8301);
    chk({15'h0, samplingActive}, 16'h1);
  endtask : configure

  task automatic normalRead;
    sampleSet(32'h1234_8765);
    tx(16'h0e00);
    for (int k = 1; k < 10; k++) begin
      tx(k == 1 ? 16'h1000 : k < 8 ? 16'h3000 + 16'((k - 2) * 512) :
        k == 8 ? 16'h0a00 : 16'h0000);
      chk(r, ex[k - 1]);
    end
    chk({15'h0, dataReady}, 16'h0);
  endtask : normalRead

  task automatic burstRead;
    sampleSet(32'hc3a1_0f96);
    tx(16'h8000);
    for (int k = 0; k < 9; k++) begin
      tx(16'h0000);
      chk(r, ex[k]);
    end
    chk({15'h0, dataReady}, 16'h0);
    tx(16'h8302);
    chk({15'h0, samplingActive}, 16'h0);
  endtask : burstRead

  task automatic testRun(input logic [15:0] cmd, input int b);
    int n;
    tx(16'hfe01);
    tx(cmd);
    tx(16'h0200);
    tx(16'h0000);
    chk({15'h0, r[b]}, 16'h1);
    for (n = 0; n < 20 && r[b] !== 1'b0; n++) begin
      tx(16'h0200);
      tx(16'h0000);
    end
    chk({15'h0, r[b]}, 16'h0);
    if (n == 20) results();
    tx(16'hfe00);
    tx(16'h0400);
    tx(16'h0000);
  endtask : testRun

  task automatic softReset;
    int n;
    tx(16'hfe01);
    tx(16'h8a80);
    chk({15'h0, swResetActive}, 16'h1);
    tx(16'hfe01);
    for (n = 0; n < 1000 && swResetActive !== 1'b0; n++) @(negedge mclk);
    chk({15'h0, swResetActive}, 16'h0);
    if (n == 1000) results();
    chk({samplingActive, 7'h0, sampleRate}, 16'h0000);
    tx(16'h7e00);
    tx(16'h0000);
    chk(r, 16'h0000);
  endtask : softReset

  initial begin
    {strobe, temp, xAcc, yAcc, zAcc, cnt} = '0;
    resetn = 1'b1;
    accFail = 4'ha;
    flashFail = 1'b1;
    nFail = 0;
    checked = 0;
    @(negedge mclk);
    resetn = 1'b0;
    repeat (8) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    chk({dataReady, samplingActive, swResetActive, sampleRate}, 16'h0);
    configure();
    normalRead();
    sampleSet(32'h0000_0000);
    burstRead();
    testRun(16'h8304, 10);
    chk({12'h0, r[15:12]}, {12'h0, accFail});
    testRun(16'h8308, 11);
    chk({15'h0, r[2]}, 16'h1);
    softReset();
    results();
  end
endmodule : acs_sequencer_bench
